// ==== crf_regs.svh ====
// Register map, field positions, reset values and codes of the receive queue block
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH

// ==================================================================
// Register offsets (byte addresses on the bus)
`define CRF_ADR_CTRL 8'h00
`define CRF_ADR_STAT 8'h04
`define CRF_ADR_ECON 8'h08
`define CRF_ADR_PIN 8'h0c
`define CRF_ADR_BT2 8'h10
`define CRF_ADR_TXSEL 8'h14
`define CRF_ADR_FEN 8'h18
`define CRF_ADR_FULL 8'h1c
`define CRF_ADR_MASK0 8'h60
`define CRF_ADR_MASK1 8'h64
`define CRF_FILT_PAGE 3'h2
`define CRF_BUF_PAGE 2'h2

// ==================================================================
// Field positions
`define CRF_CTRL_REQ 7:5
`define CRF_CTRL_RDP 3:0
`define CRF_STAT_MODE 7:5
`define CRF_STAT_CODE 4:0
`define CRF_ECON_OPM 7:6
`define CRF_ECON_HWM 5
`define CRF_PIN_CAPSEL 4

// ==================================================================
// Sizes, reset values and codes
`define CRF_NBUF 8
`define CRF_NFILT 6
`define CRF_NPROG 6
`define CRF_NDED 4'h2
`define CRF_FULL_LEN 4'h8
`define CRF_RST_BYTE 8'h00
`define CRF_CODE_NONE 5'h00
`define CRF_CODE_FIFO 5'h10
`define CRF_CODE_RXA 5'h0c
`define CRF_CODE_RXB 5'h0a
`define CRF_HWM_ONE 4'h1
`define CRF_HWM_FOUR 4'h4

`endif

// ==== crf_pkg.sv ====
// Types shared by the receive queue block
package crf_pkg;

  // ==================================================================
  // Operating modes reported and requested
  typedef enum logic [2:0] {
    CRF_MODE_NORMAL = 3'b000,
    CRF_MODE_DISABLE = 3'b001,
    CRF_MODE_LOOP = 3'b010,
    CRF_MODE_LISTEN = 3'b011,
    CRF_MODE_CONFIG = 3'b100
  } crf_mode_t;

  // Buffer organisation: legacy or queue
  typedef enum logic [1:0] {
    CRF_OPM_LEGACY = 2'b00,
    CRF_OPM_FIFO = 2'b10
  } crf_opm_t;

  // Message handed over from the assembly buffer
  typedef struct packed {
    logic [28:0] id;
    logic [31:0] data;
  } crf_msg_t;

endpackage : crf_pkg

// ==== crf_match.sv ====
// Per-filter identifier comparison with masks
`timescale 1ns/100ps
`include "crf_regs.svh"

module crf_match
  import crf_pkg::*;
(
  input wire logic [28:0] id_i,
  input wire logic [`CRF_NFILT*29-1:0] filt_i,
  input wire logic [28:0] mask0_i,
  input wire logic [28:0] mask1_i,
  output logic [`CRF_NFILT-1:0] hit_o
);

  // ==================================================================
  // One comparator per filter; filters 0 and 1 use mask 0, the rest mask 1
  genvar g;
  generate
    for (g = 0; g < `CRF_NFILT; g = g + 1) begin : g_filt
      logic [28:0] msk;
      assign msk = (g < 2) ? mask0_i : mask1_i;
      // Mask 0 bits pass, mask 1 bits must equal the filter
      assign hit_o[g] = &(~msk | ~(id_i ^ filt_i[g*29 +: 29]));
    end
  endgenerate

endmodule : crf_match

// ==== crf_top.sv ====
// Receive queue, acceptance filtering and time-stamp trigger of a CAN controller
// Overview of operation
// - Queue mode chains buffers, eight entries maximum
// - Any enabled filter match qualifies storage
// - Store at write pointer, then advance it
// - Queue is contiguous from first dedicated buffer
// - Queue ends before lowest transmit buffer
// - Queue receive sets cause code 10000
// - Read pointer field names oldest unread
// - Clearing full flag advances read pointer
// - Full flag at read pointer shows occupancy
// - Watermark bit picks one or four empty
// - Time-stamping pulses capture on each receive
// - Capture select bit replaces external input
// - Assembled identifier compared, match gets stored
// - Mask bit zero always accepts
// - Mask bit one needs equal bits
// - Legacy routes filters by mask to buffers
// - Config mode waits for idle bus
//
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps
`include "crf_regs.svh"

module crf_top
  import crf_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic msg_valid_i,
  input wire crf_msg_t msg_i,
  input wire logic bus_idle_i,
  input wire logic ext_capture_i,
  output logic cap_trig_o,
  output logic wm_irq_o,
  output logic [2:0] mode_o
);

  // ==================================================================
  // State
  logic ack_r, ack_nxt; // Bus answer
  logic [31:0] dat_r, dat_nxt; // Read data
  crf_mode_t mode_req_r, mode_req_nxt; // Requested mode
  crf_mode_t mode_r, mode_nxt; // Current mode
  logic [4:0] code_r, code_nxt; // Interrupt cause code
  crf_opm_t opm_r, opm_nxt; // Buffer organisation
  logic hwm_sel_r, hwm_sel_nxt; // Watermark threshold select
  logic capsel_r, capsel_nxt; // Capture source select
  logic [7:0] bt2_r, bt2_nxt; // Bit timing control two
  logic [`CRF_NPROG-1:0] txsel_r, txsel_nxt; // Programmable buffer is transmitter
  logic [`CRF_NFILT-1:0] fen_r, fen_nxt; // Filter enables
  logic [`CRF_NBUF-1:0] full_r, full_nxt; // Receive full flags
  logic [3:0] rdp_r, rdp_nxt; // Queue read pointer
  logic [3:0] wrp_r, wrp_nxt; // Internal write pointer
  logic [`CRF_NFILT*29-1:0] filt_r, filt_nxt; // Filter values
  logic [28:0] mask0_r, mask0_nxt; // Mask zero
  logic [28:0] mask1_r, mask1_nxt; // Mask one
  crf_msg_t buf_r [`CRF_NBUF]; // Stored messages
  crf_msg_t buf_nxt [`CRF_NBUF];
  logic cap_r, cap_nxt; // Capture trigger out
  logic wm_r, wm_nxt; // Watermark warning

  // ==================================================================
  // Combinational helpers
  logic [`CRF_NFILT-1:0] hit; // Raw filter hits
  logic [3:0] qlen; // Configured queue length
  logic [3:0] nfull; // Occupied entries inside the queue
  logic [31:0] wmerge; // Write data merged by byte lanes
  logic [31:0] rmux; // Read data selected
  logic store; // A message is stored this cycle
  logic [3:0] store_idx; // Where it goes

  crf_match i_crf_match (
    .id_i(msg_i.id),
    .filt_i(filt_r),
    .mask0_i(mask0_r),
    .mask1_i(mask1_r),
    .hit_o(hit)
  );

  // Queue ends before the lowest transmitter among programmable buffers
  always_comb begin
    qlen = `CRF_FULL_LEN;
    for (int i = `CRF_NPROG - 1; i >= 0; i--) begin
      if (txsel_r[i]) begin
        qlen = `CRF_NDED + 4'(i);
      end
    end
  end

  // Occupancy of the queue entries, for the watermark
  always_comb begin
    nfull = 4'h0;
    for (int i = 0; i < `CRF_NBUF; i++) begin
      if (4'(i) < qlen && full_nxt[i]) begin
        nfull = nfull + 4'h1;
      end
    end
  end

  // Byte-lane merge of write data onto a zero background
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmerge[b*8 +: 8] = wb_sel_i[b] ? wb_dat_i[b*8 +: 8] : `CRF_RST_BYTE;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rmux = 32'h0;
    if (wb_adr_i[7:6] == `CRF_BUF_PAGE) begin
      // Buffer page: id word then data word per entry
      rmux = wb_adr_i[2] ? buf_r[wb_adr_i[5:3]].data : {3'h0, buf_r[wb_adr_i[5:3]].id};
    end else if (wb_adr_i[7:5] == `CRF_FILT_PAGE && wb_adr_i[4:2] < 3'(`CRF_NFILT)) begin
      rmux = {3'h0, filt_r[wb_adr_i[4:2]*29 +: 29]};
    end else begin
      unique case (wb_adr_i)
        `CRF_ADR_CTRL: rmux = {24'h0, mode_req_r, 1'b0, rdp_r};
        `CRF_ADR_STAT: rmux = {24'h0, mode_r, code_r};
        `CRF_ADR_ECON: rmux = {24'h0, opm_r, hwm_sel_r, 5'h0};
        `CRF_ADR_PIN: rmux = {24'h0, 3'h0, capsel_r, 4'h0};
        `CRF_ADR_BT2: rmux = {24'h0, bt2_r};
        `CRF_ADR_TXSEL: rmux = {26'h0, txsel_r};
        `CRF_ADR_FEN: rmux = {26'h0, fen_r};
        `CRF_ADR_FULL: rmux = {24'h0, full_r};
        `CRF_ADR_MASK0: rmux = {3'h0, mask0_r};
        `CRF_ADR_MASK1: rmux = {3'h0, mask1_r};
        default: rmux = 32'h0;
      endcase
    end
  end

  // ==================================================================
  // Next-state logic of the whole block
  always_comb begin
    logic wr;
    logic [`CRF_NBUF-1:0] clr;
    wr = 1'b0;
    clr = '0;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    dat_nxt = rmux;
    mode_req_nxt = mode_req_r;
    mode_nxt = mode_r;
    code_nxt = code_r;
    opm_nxt = opm_r;
    hwm_sel_nxt = hwm_sel_r;
    capsel_nxt = capsel_r;
    bt2_nxt = bt2_r;
    txsel_nxt = txsel_r;
    fen_nxt = fen_r;
    rdp_nxt = rdp_r;
    wrp_nxt = wrp_r;
    filt_nxt = filt_r;
    mask0_nxt = mask0_r;
    mask1_nxt = mask1_r;
    buf_nxt = buf_r;
    store = 1'b0;
    store_idx = 4'h0;
    // Write takes effect at the edge that sees the answer
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
    if (wr) begin
      if (wb_adr_i[7:5] == `CRF_FILT_PAGE && wb_adr_i[4:2] < 3'(`CRF_NFILT)) begin
        filt_nxt[wb_adr_i[4:2]*29 +: 29] = wmerge[28:0];
      end else begin
        unique case (wb_adr_i)
          `CRF_ADR_CTRL: mode_req_nxt = crf_mode_t'(wmerge[`CRF_CTRL_REQ]);
          `CRF_ADR_STAT: code_nxt = `CRF_CODE_NONE; // Any write acknowledges the cause
          `CRF_ADR_ECON: begin
            opm_nxt = crf_opm_t'(wmerge[`CRF_ECON_OPM]);
            hwm_sel_nxt = wmerge[`CRF_ECON_HWM];
          end
          `CRF_ADR_PIN: capsel_nxt = wmerge[`CRF_PIN_CAPSEL];
          `CRF_ADR_BT2: bt2_nxt = wmerge[7:0];
          `CRF_ADR_TXSEL: txsel_nxt = wmerge[`CRF_NPROG-1:0];
          `CRF_ADR_FEN: fen_nxt = wmerge[`CRF_NFILT-1:0];
          `CRF_ADR_FULL: clr = full_r & ~wmerge[7:0]; // Writing zero clears a flag
          `CRF_ADR_MASK0: mask0_nxt = wmerge[28:0];
          `CRF_ADR_MASK1: mask1_nxt = wmerge[28:0];
          default: ; // Unmapped: ignored but answered
        endcase
      end
    end
    // Config waits for an idle bus, other requests act at once
    if (mode_req_r != mode_r) begin
      if (mode_req_r != CRF_MODE_CONFIG || bus_idle_i) begin
        mode_nxt = mode_req_r;
      end
    end
    full_nxt = full_r & ~clr;
    // Module advances the read pointer on clear of its flag
    if (opm_r == CRF_OPM_FIFO && clr[rdp_r[2:0]]) begin
      rdp_nxt = (rdp_r == qlen - 4'h1) ? 4'h0 : rdp_r + 4'h1;
    end
    // Message from the assembly buffer
    if (msg_valid_i && mode_r == CRF_MODE_NORMAL) begin
      if (opm_r == CRF_OPM_FIFO) begin
        // Any enabled filter qualifies; full queue drops the message
        if (|(hit & fen_r) && !full_r[wrp_r[2:0]]) begin
          store = 1'b1;
          store_idx = wrp_r;
          wrp_nxt = (wrp_r == qlen - 4'h1) ? 4'h0 : wrp_r + 4'h1;
          code_nxt = `CRF_CODE_FIFO;
        end
      end else if (|(hit[1:0] & fen_r[1:0]) && !full_r[0]) begin
        store = 1'b1;
        store_idx = 4'h0;
        code_nxt = `CRF_CODE_RXA;
      end else if (|(hit[5:2] & fen_r[5:2]) && !full_r[1]) begin
        store = 1'b1;
        store_idx = 4'h1;
        code_nxt = `CRF_CODE_RXB;
      end
    end
    // Store after clear, so a new message wins over a clear
    if (store) begin
      buf_nxt[store_idx[2:0]] = msg_i;
      full_nxt[store_idx[2:0]] = 1'b1;
    end
    // Pointers restart when configuration is entered
    if (mode_r == CRF_MODE_CONFIG) begin
      rdp_nxt = 4'h0;
      wrp_nxt = 4'h0;
    end
    // Capture trigger: own pulse or the external input
    cap_nxt = capsel_r ? store : ext_capture_i;
    // Early warning when one or four entries remain empty
    wm_nxt = (opm_r == CRF_OPM_FIFO) &&
             (qlen - nfull == (hwm_sel_r ? `CRF_HWM_ONE : `CRF_HWM_FOUR));
  end

  // ==================================================================
  // Registers; synchronous reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      mode_req_r <= CRF_MODE_CONFIG;
      mode_r <= CRF_MODE_CONFIG;
      code_r <= `CRF_CODE_NONE;
      opm_r <= CRF_OPM_LEGACY;
      hwm_sel_r <= 1'b0;
      capsel_r <= 1'b0;
      bt2_r <= `CRF_RST_BYTE;
      txsel_r <= '0;
      fen_r <= '0;
      full_r <= '0;
      rdp_r <= 4'h0;
      wrp_r <= 4'h0;
      filt_r <= '0;
      mask0_r <= '0;
      mask1_r <= '0;
      cap_r <= 1'b0;
      wm_r <= 1'b0;
      for (int i = 0; i < `CRF_NBUF; i++) begin
        buf_r[i] <= '0;
      end
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      mode_req_r <= mode_req_nxt;
      mode_r <= mode_nxt;
      code_r <= code_nxt;
      opm_r <= opm_nxt;
      hwm_sel_r <= hwm_sel_nxt;
      capsel_r <= capsel_nxt;
      bt2_r <= bt2_nxt;
      txsel_r <= txsel_nxt;
      fen_r <= fen_nxt;
      full_r <= full_nxt;
      rdp_r <= rdp_nxt;
      wrp_r <= wrp_nxt;
      filt_r <= filt_nxt;
      mask0_r <= mask0_nxt;
      mask1_r <= mask1_nxt;
      cap_r <= cap_nxt;
      wm_r <= wm_nxt;
      buf_r <= buf_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign cap_trig_o = cap_r;
  assign wm_irq_o = wm_r;
  assign mode_o = mode_r;

  // ==================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fifo_store;
    store && opm_r == CRF_OPM_FIFO;
  endsequence

  sequence s_rd_clear;
    opm_r == CRF_OPM_FIFO && mode_r != CRF_MODE_CONFIG && wb_cyc_i && wb_stb_i && wb_we_i && ack_r
      && wb_adr_i == `CRF_ADR_FULL && wb_sel_i[0] && full_r[rdp_r[2:0]] && !wb_dat_i[rdp_r[2:0]];
  endsequence

  a_bus_ack_once: assert property (wb_cyc_i && wb_stb_i && !ack_r |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
  a_fifo_cause_code: assert property (s_fifo_store |=> code_r == `CRF_CODE_FIFO)
    else $error("queue receive did not set cause code");
  a_wr_ptr_step: assert property (s_fifo_store and (wrp_r != qlen - 4'h1) && mode_r != CRF_MODE_CONFIG
    |=> wrp_r == $past(wrp_r) + 4'h1)
    else $error("write pointer did not advance");
  a_wr_ptr_wrap: assert property (s_fifo_store and wrp_r == qlen - 4'h1 |=> wrp_r == 4'h0)
    else $error("write pointer did not wrap");
  a_rd_ptr_step: assert property (s_rd_clear |=> rdp_r != $past(rdp_r))
    else $error("read pointer stuck after clear");
  a_queue_len_ends: assert property (txsel_r[0] |-> qlen == `CRF_NDED)
    else $error("queue length wrong for first transmitter");
  a_queue_len_full: assert property (txsel_r == '0 |-> qlen == `CRF_FULL_LEN)
    else $error("queue not eight deep");
  a_config_idle: assert property (mode_req_r == CRF_MODE_CONFIG && mode_r != CRF_MODE_CONFIG
    && !bus_idle_i |=> mode_o != CRF_MODE_CONFIG)
    else $error("config entered on busy bus");
  a_cap_pulse: assert property (store && capsel_r |=> cap_trig_o ##1 (cap_trig_o == $past(store)))
    else $error("no capture pulse on receive");
  a_mask_zero_pass: assert property (mask0_r == '0 |-> hit[1:0] == 2'h3)
    else $error("zero mask rejected");
  a_mask_one_reject: assert property (mask0_r[1] && (msg_i.id[1] != filt_r[1]) |-> !hit[0])
    else $error("mismatch accepted under mask");
  a_legacy_route: assert property (store && opm_r == CRF_OPM_LEGACY && store_idx == 4'h0 |=> full_r[0])
    else $error("legacy message not in first buffer");

endmodule : crf_top

// ==== crf_engine_model.sv ====
// Behavioural protocol engine that hands assembled messages to the receive block
`timescale 1ns/100ps

module crf_engine_model
  import crf_pkg::*;
(
  input wire logic clk_i,
  output logic msg_valid_o,
  output crf_msg_t msg_o,
  output logic bus_idle_o
);
  // ==================================================================
  // Idle line, nothing assembled yet
  initial begin
    msg_valid_o = 1'b0;
    msg_o = '0;
    bus_idle_o = 1'b1;
  end

  // ==================================================================
  // One-cycle hand-over of a finished message from the assembly buffer
  // Fields are inverted afterwards so stale contents never pass for fresh ones
  task automatic send(input logic [28:0] id, input logic [31:0] dat);
    @(posedge clk_i);
    msg_valid_o <= 1'b1;
    msg_o <= '{id: id, data: dat};
    @(posedge clk_i);
    msg_valid_o <= 1'b0;
    msg_o <= ~{id, dat};
  endtask : send

  // Bus activity seen by the engine; a config request waits on it
  task automatic set_idle(input logic v);
    @(posedge clk_i);
    bus_idle_o <= v;
  endtask : set_idle
endmodule : crf_engine_model

// ==== test_crf_top.sv ====
// Self-checking bench for the receive queue block
`timescale 1ns/100ps
`include "crf_regs.svh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin mismatches++; $display("Error %s expected %h seen %h", nm, ex, got); end end

module test_crf_top
  import crf_pkg::*;
;
  // ==================================================================
  // Signals
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic we = 1'b0;
  logic cyc = 1'b0;
  logic ext_cap = 1'b0;
  logic [31:0] rdat;
  logic ack;
  logic msg_valid;
  crf_msg_t msg;
  logic bus_idle;
  logic cap_trig;
  logic wm_irq;
  logic [2:0] mode;
  logic [31:0] rd_q; // Data taken at the acknowledging edge
  int mismatches = 0;
  int checked = 0;
  localparam logic [28:0] ID_A = 29'h0abc_1234; // Filter zero value
  localparam logic [28:0] ID_B = 29'h1555_0f0f; // Filter two value

  // ==================================================================
  // Design and far-side engine
  crf_top i_crf_top (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hf),
    .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .msg_valid_i(msg_valid),
    .msg_i(msg), .bus_idle_i(bus_idle), .ext_capture_i(ext_cap), .cap_trig_o(cap_trig), .wm_irq_o(wm_irq),
    .mode_o(mode));
  crf_engine_model i_crf_engine_model (.clk_i(clk_i), .msg_valid_o(msg_valid), .msg_o(msg),
    .bus_idle_o(bus_idle));

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ==================================================================
  // Helpers
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  // Classic single cycle; strobe tied to cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 16);
    rd_q = rdat;
    cyc <= 1'b0;
    if (n >= 16) begin
      mismatches++;
      close_out();
    end
  endtask : wb

  // Bounded wait for the reported mode
  task automatic wait_mode(input logic [2:0] m);
    int n;
    for (n = 0; n < 50 && mode !== m; n++) tick(1);
    if (mode !== m) begin
      mismatches++;
      close_out();
    end
  endtask : wait_mode

  // Message hand-over; capture output looked at in its one cycle
  task automatic snd(input logic [28:0] id, input logic [31:0] d, input logic cap);
    i_crf_engine_model.send(id, d);
    #1;
    `CHK("cap_trig", cap, cap_trig)
  endtask : snd

  // ==================================================================
  // Scenarios
  task automatic t_regs;
    `CHK("mode reset", 3'b100, mode)
    wb(1'b0, `CRF_ADR_STAT, 32'h0);
    `CHK("status reset", 32'h80, rd_q)
    wb(1'b1, `CRF_ADR_BT2, 32'ha5);
    wb(1'b0, `CRF_ADR_BT2, 32'h0);
    `CHK("bit timing", 32'ha5, rd_q)
    wb(1'b0, 8'h3c, 32'h0);
    `CHK("unmapped", 32'h0, rd_q)
    @(posedge clk_i);
    ext_cap <= 1'b1;
    tick(2);
    `CHK("ext capture", 1'b1, cap_trig)
    ext_cap <= 1'b0;
    $display("Register test done");
  endtask : t_regs

  task automatic t_mode;
    i_crf_engine_model.set_idle(1'b0);
    wb(1'b1, `CRF_ADR_CTRL, 32'h0);
    tick(1);
    `CHK("mode normal", 3'b000, mode)
    wb(1'b1, `CRF_ADR_CTRL, 32'h80);
    tick(4);
    `CHK("config held", 3'b000, mode)
    i_crf_engine_model.set_idle(1'b1);
    wait_mode(3'b100);
    // Filters and masks only change while configuring; the block takes these writes in any mode
    wb(1'b1, 8'h40, {3'h0, ID_A});
    wb(1'b1, 8'h48, {3'h0, ID_B});
    wb(1'b1, `CRF_ADR_MASK0, 32'h1fff_fffe);
    wb(1'b1, `CRF_ADR_MASK1, 32'h1fff_ffff);
    wb(1'b1, `CRF_ADR_FEN, 32'h05);
    $display("Mode test done");
  endtask : t_mode

  task automatic t_legacy;
    wb(1'b1, `CRF_ADR_CTRL, 32'h0);
    snd(ID_B, 32'h1, 1'b0);
    wb(1'b0, `CRF_ADR_FULL, 32'h0);
    `CHK("legacy b", 32'h2, rd_q)
    wb(1'b0, `CRF_ADR_STAT, 32'h0);
    `CHK("code b", {27'h0, `CRF_CODE_RXB}, rd_q)
    snd(ID_A, 32'h2, 1'b0);
    wb(1'b0, `CRF_ADR_FULL, 32'h0);
    `CHK("legacy a", 32'h3, rd_q)
    wb(1'b0, `CRF_ADR_STAT, 32'h0);
    `CHK("code a", {27'h0, `CRF_CODE_RXA}, rd_q)
    // Any status write acknowledges the cause code
    wb(1'b1, `CRF_ADR_STAT, 32'h0);
    wb(1'b0, `CRF_ADR_STAT, 32'h0);
    `CHK("code cleared", 32'h0, rd_q)
    $display("Legacy test done");
  endtask : t_legacy

  task automatic t_fifo;
    wb(1'b1, `CRF_ADR_CTRL, 32'h80);
    wait_mode(3'b100);
    wb(1'b1, `CRF_ADR_FULL, 32'h0);
    wb(1'b1, `CRF_ADR_ECON, 32'h80);
    wb(1'b1, `CRF_ADR_TXSEL, 32'h08); // Programmable buffer three transmits: five entries
    wb(1'b1, `CRF_ADR_PIN, 32'h10); // Own pulse feeds a capture unit in mode 0011
    wb(1'b1, `CRF_ADR_CTRL, 32'h0);
    snd(ID_A ^ 29'h2, 32'h9, 1'b0);
    wb(1'b0, `CRF_ADR_FULL, 32'h0);
    `CHK("masked reject", 32'h0, rd_q)
    snd(ID_A ^ 29'h1, 32'h0, 1'b1);
    wb(1'b0, `CRF_ADR_STAT, 32'h0);
    `CHK("queue code", {27'h0, `CRF_CODE_FIFO}, rd_q)
    `CHK("four empty", 1'b1, wm_irq)
    for (int i = 1; i < 5; i++) snd(ID_A, 32'(i), 1'b1);
    snd(ID_A, 32'h55, 1'b0);
    wb(1'b0, `CRF_ADR_FULL, 32'h0);
    `CHK("queue full", 32'h1f, rd_q)
    for (int i = 0; i < 5; i++) begin
      wb(1'b0, 8'(8'h84 + 8 * i), 32'h0);
      `CHK("entry data", 32'(i), rd_q)
      wb(1'b0, `CRF_ADR_CTRL, 32'h0);
      `CHK("read pointer", 4'(i), rd_q[3:0])
      wb(1'b1, `CRF_ADR_FULL, 32'(8'hff ^ (8'h1 << i)));
    end
    wb(1'b0, `CRF_ADR_CTRL, 32'h0);
    `CHK("pointer wrap", 4'h0, rd_q[3:0])
    wb(1'b0, `CRF_ADR_FULL, 32'h0);
    `CHK("queue empty", 32'h0, rd_q)
    wb(1'b1, `CRF_ADR_ECON, 32'ha0);
    for (int i = 0; i < 4; i++) snd(ID_A, 32'(i), 1'b1);
    tick(1);
    `CHK("one empty", 1'b1, wm_irq)
    $display("Queue test done");
  endtask : t_fifo

  // Queue length against the lowest transmitter
  task automatic t_len;
    wb(1'b1, `CRF_ADR_CTRL, 32'h80);
    wait_mode(3'b100);
    wb(1'b1, `CRF_ADR_FULL, 32'h0);
    wb(1'b1, `CRF_ADR_TXSEL, 32'h20); // Transmitter at the highest buffer keeps seven entries
    wb(1'b1, `CRF_ADR_CTRL, 32'h0);
    for (int i = 0; i < 6; i++) snd(ID_B, 32'(i), 1'b1);
    tick(1);
    `CHK("seven deep", 1'b1, wm_irq)
    wb(1'b1, `CRF_ADR_CTRL, 32'h80);
    wait_mode(3'b100);
    wb(1'b1, `CRF_ADR_FULL, 32'h0);
    wb(1'b1, `CRF_ADR_TXSEL, 32'h01); // First programmable buffer transmits: two entries
    wb(1'b1, `CRF_ADR_CTRL, 32'h0);
    snd(ID_B, 32'h7, 1'b1);
    tick(1);
    `CHK("two deep", 1'b1, wm_irq)
    snd(ID_B, 32'h8, 1'b1);
    snd(ID_B, 32'h9, 1'b0);
    `CHK("two full", 1'b0, wm_irq)
    $display("Length test done");
  endtask : t_len

  // ==================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    t_regs();
    t_mode();
    t_legacy();
    t_fifo();
    t_len();
    close_out();
  end
endmodule : test_crf_top
